/* rtl/tcc_chan_if.sv */
`default_nettype none
interface tcc_chan_if import tcc_pkg::*; ();
	tcc_chv_t    ios;
	tcc_chv_t    mask;
	tcc_chv_t    odata;
	tcc_chv_t    force_evt;
	tcc_chv_t    match;
	tcc_chv_t    overflow_toggle_bit;
	logic [15:0] act;
	logic        ovf;
	tcc_chv_t    level;
	tcc_chv_t    oe_n;
	modport ctrl (output ios, mask, odata, force_evt, match, overflow_toggle_bit, act, ovf,
		input level, oe_n);
	modport chan (input ios, mask, odata, force_evt, match, overflow_toggle_bit, act, ovf,
		output level, oe_n);
endinterface : tcc_chan_if
`default_nettype wire

/* rtl/tcc_channels.sv */
`default_nettype none
module tcc_channels
	import tcc_pkg::*;
(
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Channel control and pin state
	tcc_chan_if.chan  cif
);
	logic     ev7;
	tcc_chv_t ovr_sel;
	tcc_chv_t level_r;
	tcc_chv_t oe_n_r;

	// Forced channel 7 counts as a successful compare too
	assign ev7 = cif.ios[CH_HI] & (cif.match[CH_HI] | cif.force_evt[CH_HI]);
	assign ovr_sel = cif.mask & cif.ios;
	assign cif.level = level_r;
	assign cif.oe_n = oe_n_r;

	genvar k;
	generate
		for (k = CH_LO; k <= CH_HI; k++) begin : g_ch
			logic [1:0] act_k;
			logic       ev_k;
			logic       lvl_nxt;
			assign act_k = cif.act[2*k+1:2*k];
			assign ev_k = cif.ios[k] & (cif.match[k] | cif.force_evt[k]); // R02
			always_comb begin
				lvl_nxt = level_r[k];
				if (ev7 && ovr_sel[k]) begin
					lvl_nxt = cif.odata[k]; // R04 R06
				end else if (cif.ovf && cif.overflow_toggle_bit[k] && cif.ios[k]) begin
					lvl_nxt = ~level_r[k]; // R17 R18
				end else if (ev_k) begin
					case (act_k) // R21
						ACT_TOGGLE: lvl_nxt = ~level_r[k];
						ACT_CLEAR:  lvl_nxt = 1'h0;
						ACT_SET:    lvl_nxt = 1'h1;
						default:    lvl_nxt = level_r[k];
					endcase
				end
			end
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					level_r[k] <= 1'h0;
					oe_n_r[k]  <= 1'h1;
				end else begin
					level_r[k] <= lvl_nxt;
					oe_n_r[k]  <= ~(cif.ios[k] & ((act_k != ACT_OFF) | cif.mask[k])); // R05 R20
				end
			end
		end
	endgenerate

	property p_override;
		@(posedge pclk) disable iff (!presetn)
		ev7 |=> ((level_r ^ $past(cif.odata)) & $past(ovr_sel)) == '0;
	endproperty
	a_override: assert property (p_override) // R06
		else $error("override data missing on masked pins");
endmodule : tcc_channels
`default_nettype wire

/* rtl/tcc_pkg.sv */
// How it works
// [R01] Force register always reads back as zero
// [R02] Force bit performs channel action, no flag
// [R03] Force beats coincident match; flag stays clear
// [R04] Channel 7 compare overrides channels 6 to 2
// [R05] Mask bit makes output-compare pin an output
// [R06] Channel 7 match copies data bits to masked pins
// [R07] Sixteen-bit counter counts up each prescaled tick
// [R08] Counter writes only load in test mode
// [R09] First period after counter write may vary
// [R10] Master accesses counter as one word
// [R11] Enable bit clear stops timer and counter
// [R12] Divide-by-64 clock comes from running prescaler
// [R13] Wait-stop halts timer and accumulator clock
// [R14] Fast clear: capture read, compare write clear flag
// [R15] Fast clear: counter access clears wrap flag
// [R16] Fast clear: pulse count access clears both flags
// [R17] Toggle-on-overflow inverts output pin at wrap
// [R18] Toggle beats force, yields to channel 7 override
// [R19] Freeze-stop halts counter while processor frozen
// [R20] Select bit: zero capture, one compare
// [R21] Action codes: off, toggle, clear, set
// [R22] Without fast clear, only write-one clears flags
// [R23] Wrap from all ones sets flag, drives toggles
`default_nettype none
package tcc_pkg;
	localparam int CH_HI = 7;
	localparam int CH_LO = 2;
	localparam int ADDR_LSB = 2;
	localparam int IDX_W = 6;
	localparam int PRE_W = 7;
	typedef logic [CH_HI:CH_LO] tcc_chv_t;
	typedef logic [IDX_W-1:0]   tcc_idx_t;
	localparam tcc_idx_t IDX_SELECT    = 6'h00;
	localparam tcc_idx_t IDX_FORCE     = 6'h01;
	localparam tcc_idx_t IDX_MASK      = 6'h02;
	localparam tcc_idx_t IDX_ODATA     = 6'h03;
	localparam tcc_idx_t IDX_CNT_HI    = 6'h04;
	localparam tcc_idx_t IDX_CNT_LO    = 6'h05;
	localparam tcc_idx_t IDX_SCR1      = 6'h06;
	localparam tcc_idx_t IDX_OVERFLOW_TOGGLE_ENABLE      = 6'h07;
	localparam tcc_idx_t IDX_ACT1      = 6'h08;
	localparam tcc_idx_t IDX_ACT2      = 6'h09;
	localparam tcc_idx_t IDX_SCR2      = 6'h0d;
	localparam tcc_idx_t IDX_CHFLG     = 6'h0e;
	localparam tcc_idx_t IDX_OVFLG     = 6'h0f;
	localparam tcc_idx_t IDX_CMP_FIRST = 6'h14;
	localparam tcc_idx_t IDX_CMP_LAST  = 6'h1f;
	localparam tcc_idx_t IDX_PFLG      = 6'h21;
	localparam tcc_idx_t IDX_PCNT_HI   = 6'h22;
	localparam tcc_idx_t IDX_PCNT_LO   = 6'h23;
	localparam int SCR1_EN   = 7;
	localparam int SCR1_WAIT = 6;
	localparam int SCR1_FRZ  = 5;
	localparam int SCR1_FAST = 4;
	localparam int SCR1_LSB  = 4;
	localparam int OVFLG_WRAP = 7;
	localparam int PFLG_WRAP  = 1;
	localparam int PFLG_IN    = 0;
	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [15:0] CNT_MAX  = 16'hffff;
	localparam logic [15:0] CNT_ONE  = 16'h0001;
	localparam logic [5:0]  DIV64_END = 6'h3f;
	localparam logic [PRE_W-1:0] PRE_ALL = 7'h7f;
	localparam logic [1:0] ACT_OFF    = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR  = 2'h2;
	localparam logic [1:0] ACT_SET    = 2'h3;
endpackage : tcc_pkg
`default_nettype wire

/* rtl/tcc_prescaler.sv */
`default_nettype none
module tcc_prescaler
	import tcc_pkg::*;
(
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Control
	input  wire logic       run,
	input  wire logic [2:0] sel,
	// Enables
	output var  logic       tick,
	output var  logic       div64
);
	logic [PRE_W-1:0] pre_r;
	logic [PRE_W-1:0] lim;

	assign lim = ~(PRE_ALL << sel);

	// Holds its phase when stopped; counter writes are not aligned to it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_r <= '0;
		end else if (run) begin
			pre_r <= pre_r + 7'h01; // R09
		end
	end

	always_comb begin
		tick  = run & ((pre_r & lim) == lim); // R11
		div64 = run & (pre_r[5:0] == DIV64_END); // R12
	end
endmodule : tcc_prescaler
`default_nettype wire

/* rtl/tcc_top.sv */
// The implementer's own choice: register access over APB.
`default_nettype none
module tcc_top
	import tcc_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	// Processor state
	input  wire logic        test_mode,
	input  wire logic        cpu_wait,
	input  wire logic        cpu_freeze,
	// Capture events and pulse accumulator
	input  wire logic [7:0]  capture_evt,
	input  wire logic        pulse_wrap_evt,
	input  wire logic        pulse_input_evt,
	input  wire logic [15:0] pulse_count,
	output var  logic        pulse_clk64,
	// Timer pins and flags
	output var  logic [7:0]  compare_output,
	output var  logic [7:0]  pin_oe_n,
	output var  logic [7:0]  channel_flags,
	output var  logic        wrap_flag
);
	tcc_chv_t    ios_r;
	tcc_chv_t    mask_r;
	tcc_chv_t    odata_r;
	tcc_chv_t    tov_r;
	tcc_chv_t    force_r;
	tcc_chv_t    flags_r;
	tcc_chv_t    match;
	tcc_chv_t    cmp_hit;
	tcc_chv_t    fast_clr;
	logic [7:0]  act1_r;
	logic [7:0]  act2_r;
	logic [3:0]  scr1_r;
	logic [2:0]  pre_sel_r;
	logic [15:0] cnt_r;
	logic [15:0] cmp_r [CH_HI:CH_LO];
	logic        cnt_upd_r;
	logic        wrap_r;
	logic        pwrap_r;
	logic        pin_r;
	logic        pready_r;
	logic [31:0] prdata_r;
	logic        pslverr_r;
	logic        pa_clk_r;
	tcc_idx_t    idx;
	tcc_idx_t    cmp_off;
	logic        setup;
	logic        access;
	logic        wr_en;
	logic        rd_en;
	logic        is_cmp;
	logic        cnt_sel;
	logic        pcnt_sel;
	logic        fast;
	logic        en;
	logic        wait_halt;
	logic        frz_halt;
	logic        pre_run;
	logic        tick_raw;
	logic        tick;
	logic        div64;
	logic        ovf_evt;
	logic        cnt_load;
	logic        bad;
	logic [31:0] rdata_nxt;

	tcc_chan_if cif ();

	assign idx      = paddr[7:ADDR_LSB];
	assign setup    = psel & ~penable;
	assign access   = psel & penable & pready_r;
	assign wr_en    = access & pwrite & ~pslverr_r;
	assign rd_en    = access & ~pwrite & ~pslverr_r;
	assign is_cmp   = (idx >= IDX_CMP_FIRST) && (idx <= IDX_CMP_LAST);
	assign cmp_off  = idx - IDX_CMP_FIRST;
	assign cnt_sel  = (idx == IDX_CNT_HI) || (idx == IDX_CNT_LO);
	assign pcnt_sel = (idx == IDX_PCNT_HI) || (idx == IDX_PCNT_LO);
	assign fast     = scr1_r[SCR1_FAST-SCR1_LSB];
	assign en       = scr1_r[SCR1_EN-SCR1_LSB];
	assign wait_halt = scr1_r[SCR1_WAIT-SCR1_LSB] & cpu_wait;
	assign frz_halt = scr1_r[SCR1_FRZ-SCR1_LSB] & cpu_freeze;
	assign pre_run  = en & ~wait_halt; // R11 R13
	assign tick     = tick_raw & ~frz_halt; // R19
	assign ovf_evt  = tick && (cnt_r == CNT_MAX); // R23
	assign cnt_load = wr_en && cnt_sel && test_mode; // R08

	tcc_prescaler u_pre (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (pre_run),
		.sel     (pre_sel_r),
		.tick    (tick_raw),
		.div64   (div64)
	);

	assign cif.ios       = ios_r;
	assign cif.mask      = mask_r;
	assign cif.odata     = odata_r;
	assign cif.force_evt = force_r;
	assign cif.match     = match;
	assign cif.overflow_toggle_bit       = tov_r;
	assign cif.act       = {act1_r, act2_r};
	assign cif.ovf       = ovf_evt;

	tcc_channels u_chan (
		.pclk    (pclk),
		.presetn (presetn),
		.cif     (cif)
	);

	// Register file decode and read data
	always_comb begin
		rdata_nxt = '0;
		bad = (paddr[ADDR_LSB-1:0] != 2'h0);
		case (idx)
			IDX_SELECT:  rdata_nxt = 32'({ios_r, 2'h0});
			IDX_FORCE:   rdata_nxt = '0; // R01
			IDX_MASK:    rdata_nxt = 32'({mask_r, 2'h0});
			IDX_ODATA:   rdata_nxt = 32'({odata_r, 2'h0});
			IDX_CNT_HI:  rdata_nxt = 32'(cnt_r);
			IDX_CNT_LO:  rdata_nxt = 32'(cnt_r[7:0]);
			IDX_SCR1:    rdata_nxt = 32'({scr1_r, 4'h0});
			IDX_OVERFLOW_TOGGLE_ENABLE:    rdata_nxt = 32'({tov_r, 2'h0});
			IDX_ACT1:    rdata_nxt = 32'(act1_r);
			IDX_ACT2:    rdata_nxt = 32'({act2_r[7:4], 4'h0});
			IDX_SCR2:    rdata_nxt = 32'(pre_sel_r);
			IDX_CHFLG:   rdata_nxt = 32'({flags_r, 2'h0});
			IDX_OVFLG:   rdata_nxt = 32'({wrap_r, 7'h00});
			IDX_PFLG:    rdata_nxt = 32'({pwrap_r, pin_r});
			IDX_PCNT_HI: rdata_nxt = 32'(pulse_count);
			IDX_PCNT_LO: rdata_nxt = 32'(pulse_count[7:0]);
			default: begin
				bad = 1'h1;
				for (int c = CH_LO; c <= CH_HI; c++) begin
					if (cmp_hit[c]) begin
						bad = (paddr[ADDR_LSB-1:0] != 2'h0);
						rdata_nxt = idx[0] ? 32'(cmp_r[c][7:0]) : 32'(cmp_r[c]);
					end
				end
			end
		endcase
		if (bad) begin
			rdata_nxt = '0;
		end
	end

	// APB handshake: one access cycle, no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'h0;
			pslverr_r <= 1'h0;
			prdata_r  <= '0;
		end else begin
			pready_r  <= setup;
			pslverr_r <= setup & bad;
			if (setup && !pwrite) begin
				prdata_r <= rdata_nxt;
			end
		end
	end

	// Control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ios_r     <= '0;
			mask_r    <= '0;
			odata_r   <= '0;
			tov_r     <= '0;
			act1_r    <= RST_BYTE;
			act2_r    <= RST_BYTE;
			scr1_r    <= '0;
			pre_sel_r <= '0;
		end else if (wr_en) begin
			case (idx)
				IDX_SELECT: ios_r     <= pwdata[CH_HI:CH_LO]; // R20
				IDX_MASK:   mask_r    <= pwdata[CH_HI:CH_LO];
				IDX_ODATA:  odata_r   <= pwdata[CH_HI:CH_LO];
				IDX_OVERFLOW_TOGGLE_ENABLE:   tov_r     <= pwdata[CH_HI:CH_LO];
				IDX_ACT1:   act1_r    <= pwdata[7:0];
				IDX_ACT2:   act2_r    <= {pwdata[7:4], 4'h0};
				IDX_SCR1:   scr1_r    <= pwdata[7:SCR1_LSB];
				IDX_SCR2:   pre_sel_r <= pwdata[2:0];
				default:    ios_r     <= ios_r;
			endcase
		end
	end

	// Force bits live for one cycle only, so nothing is held to read back
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			force_r <= '0;
		end else if (wr_en && idx == IDX_FORCE) begin
			force_r <= pwdata[CH_HI:CH_LO]; // R01 R02
		end else begin
			force_r <= '0;
		end
	end

	// Main counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r     <= RST_WORD;
			cnt_upd_r <= 1'h0;
		end else begin
			cnt_upd_r <= tick;
			if (cnt_load) begin
				cnt_r <= (idx == IDX_CNT_HI) ? pwdata[15:0] :
					{cnt_r[15:8], pwdata[7:0]}; // R08 R09
			end else if (tick) begin
				cnt_r <= cnt_r + CNT_ONE; // R07 R11
			end
		end
	end

	// Per channel compare value, capture, match and flag
	genvar k;
	generate
		for (k = CH_LO; k <= CH_HI; k++) begin : g_ch
			logic set_k;
			logic clr_k;
			assign cmp_hit[k] = is_cmp && (cmp_off[3:1] == 3'(k - CH_LO));
			assign match[k] = cnt_upd_r && ios_r[k] && (cnt_r == cmp_r[k]);
			assign fast_clr[k] = fast && cmp_hit[k] &&
				((rd_en && !ios_r[k]) || (wr_en && ios_r[k])); // R14
			assign set_k = (match[k] & ~force_r[k]) |
				(capture_evt[k] & ~ios_r[k]); // R03
			assign clr_k = (wr_en && idx == IDX_CHFLG && pwdata[k]) ||
				fast_clr[k]; // R22
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cmp_r[k] <= RST_WORD;
				end else if (capture_evt[k] && !ios_r[k]) begin
					cmp_r[k] <= cnt_r;
				end else if (wr_en && cmp_hit[k]) begin
					cmp_r[k] <= idx[0] ? {cmp_r[k][15:8], pwdata[7:0]} :
						pwdata[15:0];
				end
			end
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					flags_r[k] <= 1'h0;
				end else begin
					flags_r[k] <= set_k | (flags_r[k] & ~clr_k);
				end
			end
		end
	endgenerate

	// Wrap and pulse flags; a set in the clearing cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wrap_r <= 1'h0;
		end else if (ovf_evt) begin
			wrap_r <= 1'h1; // R23
		end else if ((wr_en && idx == IDX_OVFLG && pwdata[OVFLG_WRAP]) ||
			(fast && (wr_en || rd_en) && cnt_sel)) begin
			wrap_r <= 1'h0; // R15 R22
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwrap_r <= 1'h0;
			pin_r   <= 1'h0;
		end else begin
			if (pulse_wrap_evt) begin
				pwrap_r <= 1'h1;
			end else if ((fast && (wr_en || rd_en) && pcnt_sel) ||
				(wr_en && idx == IDX_PFLG && pwdata[PFLG_WRAP])) begin
				pwrap_r <= 1'h0; // R16
			end
			if (pulse_input_evt) begin
				pin_r <= 1'h1;
			end else if ((fast && (wr_en || rd_en) && pcnt_sel) ||
				(wr_en && idx == IDX_PFLG && pwdata[PFLG_IN])) begin
				pin_r <= 1'h0; // R16
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pa_clk_r <= 1'h0;
		end else begin
			pa_clk_r <= div64; // R12 R13
		end
	end

	assign prdata         = prdata_r;
	assign pready         = pready_r;
	assign pslverr        = pslverr_r;
	assign pulse_clk64    = pa_clk_r;
	assign compare_output = {cif.level, 2'h0};
	assign pin_oe_n       = {cif.oe_n, 2'h3};
	assign channel_flags  = {flags_r, 2'h0};
	assign wrap_flag      = wrap_r;

	property p_force_reads_zero;
		@(posedge pclk) disable iff (!presetn)
		(setup && !pwrite && paddr == {IDX_FORCE, 2'h0}) |=>
			prdata == 32'h00000000;
	endproperty
	a_force_reads_zero: assert property (p_force_reads_zero) // R01
		else $error("force register read not zero");

	property p_force_no_flag;
		@(posedge pclk) disable iff (!presetn)
		(force_r != '0 && (force_r & ios_r & ~capture_evt[CH_HI:CH_LO]) != '0)
		|=> ((flags_r & ~$past(flags_r)) & $past(force_r) & $past(ios_r)) == '0;
	endproperty
	a_force_no_flag: assert property (p_force_no_flag) // R03
		else $error("forced compare set a flag");

	property p_count_step;
		@(posedge pclk) disable iff (!presetn)
		(tick && !cnt_load) |=> cnt_r == $past(cnt_r) + CNT_ONE;
	endproperty
	a_count_step: assert property (p_count_step) // R07
		else $error("counter did not step by one");

	property p_no_normal_write;
		@(posedge pclk) disable iff (!presetn)
		(!test_mode && !tick) |=> cnt_r == $past(cnt_r);
	endproperty
	a_no_normal_write: assert property (p_no_normal_write) // R08
		else $error("counter changed without tick");

	property p_disabled_stops;
		@(posedge pclk) disable iff (!presetn)
		(!en && !cnt_load) |=> $stable(cnt_r);
	endproperty
	a_disabled_stops: assert property (p_disabled_stops) // R11
		else $error("counter ran while disabled");

	property p_no_clk64_off;
		@(posedge pclk) disable iff (!presetn)
		(!en)[*2] |-> !pulse_clk64;
	endproperty
	a_no_clk64_off: assert property (p_no_clk64_off) // R12
		else $error("divide-by-64 clock while timer off");

	property p_wait_halt;
		@(posedge pclk) disable iff (!presetn)
		wait_halt ##1 wait_halt |-> !pulse_clk64 && $stable(cnt_r);
	endproperty
	a_wait_halt: assert property (p_wait_halt) // R13
		else $error("timer ran during wait stop");

	property p_freeze_halt;
		@(posedge pclk) disable iff (!presetn)
		(frz_halt && !cnt_load) |=> $stable(cnt_r);
	endproperty
	a_freeze_halt: assert property (p_freeze_halt) // R19
		else $error("counter ran during freeze stop");

	property p_fast_wrap_clear;
		@(posedge pclk) disable iff (!presetn)
		(fast && (wr_en || rd_en) && cnt_sel && !ovf_evt) |=> !wrap_flag;
	endproperty
	a_fast_wrap_clear: assert property (p_fast_wrap_clear) // R15
		else $error("wrap flag survived counter access");

	property p_fast_pulse_clear;
		@(posedge pclk) disable iff (!presetn)
		(fast && (wr_en || rd_en) && pcnt_sel && !pulse_wrap_evt &&
			!pulse_input_evt) |=> !pwrap_r && !pin_r;
	endproperty
	a_fast_pulse_clear: assert property (p_fast_pulse_clear) // R16
		else $error("pulse flags survived count access");

	property p_wrap_sets;
		@(posedge pclk) disable iff (!presetn)
		ovf_evt |=> wrap_flag && cnt_r == RST_WORD;
	endproperty
	a_wrap_sets: assert property (p_wrap_sets) // R23
		else $error("wrap did not set flag");
endmodule : tcc_top
`default_nettype wire

/* verif/tb.sv */
`default_nettype none
module tb
	import tcc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        test_mode;
	logic        cpu_wait;
	logic        cpu_freeze;
	logic [7:0]  capture_evt;
	logic        pulse_wrap_evt;
	logic        pulse_input_evt;
	logic [15:0] pulse_count;
	logic        pulse_clk64;
	logic [7:0]  compare_output;
	logic [7:0]  pin_oe_n;
	logic [7:0]  channel_flags;
	logic        wrap_flag;
	logic [7:0]  ext_drive;
	logic [7:0]  pin_level;
	logic [31:0] v1;
	logic [31:0] v2;
	logic        e;
	int          failures;
	int          compares;
	logic [1:0]  act_code [4] = '{ACT_SET, ACT_CLEAR, ACT_TOGGLE, ACT_TOGGLE};
	logic        act_exp  [4] = '{1'h1, 1'h0, 1'h1, 1'h0};
	logic [7:0]  md_scr   [6] = '{8'h80, 8'h00, 8'hc0, 8'h80, 8'ha0, 8'h80};
	logic        md_wt    [6] = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0};
	logic        md_fz    [6] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1};
	logic [15:0] md_d     [6] = '{16'h3, 16'h0, 16'h0, 16'h3, 16'h0, 16'h3};

	tcc_top i_tcc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.test_mode(test_mode), .cpu_wait(cpu_wait), .cpu_freeze(cpu_freeze),
		.capture_evt(capture_evt), .pulse_wrap_evt(pulse_wrap_evt),
		.pulse_input_evt(pulse_input_evt), .pulse_count(pulse_count),
		.pulse_clk64(pulse_clk64), .compare_output(compare_output),
		.pin_oe_n(pin_oe_n), .channel_flags(channel_flags),
		.wrap_flag(wrap_flag));
	tcc_pin_model i_tcc_pin_model (.pclk(pclk), .presetn(presetn),
		.compare_output(compare_output), .pin_oe_n(pin_oe_n),
		.ext_drive(ext_drive), .pin_level(pin_level),
		.capture_evt(capture_evt));

	initial begin
		pclk = 1'h0;
		forever #25 pclk = ~pclk;
	end

	task automatic final_report;
		if (failures == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : final_report

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc

	// Waits for pready as long as it takes; the watchdog ends a hang
	task automatic apb(input logic wr, input tcc_idx_t idx,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= wr;
		paddr   <= {idx, 2'h0};
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task automatic wr(input tcc_idx_t idx, input logic [31:0] wd);
		logic [31:0] d;
		logic        r;
		apb(1'h1, idx, wd, d, r);
	endtask : wr

	task automatic rdc(input tcc_idx_t idx, input logic [31:0] exp);
		logic [31:0] d;
		logic        r;
		apb(1'h0, idx, 32'h0, d, r);
		check($sformatf("reg_%h", idx), d, exp);
	endtask : rdc

	task automatic cnt64(input int exp);
		int n;
		n = 0;
		repeat (128) begin
			@(posedge pclk);
			if (pulse_clk64 === 1'h1) begin
				n++;
			end
		end
		check("div64", 32'(n), 32'(exp));
	endtask : cnt64

	initial begin
		#(4000 * 50);
		failures++;
		final_report();
	end

	initial begin
		presetn <= 1'h0;
		psel <= 1'h0;
		penable <= 1'h0;
		pwrite <= 1'h0;
		paddr <= 8'h00;
		pwdata <= 32'h0;
		test_mode <= 1'h0;
		cpu_wait <= 1'h0;
		cpu_freeze <= 1'h0;
		pulse_wrap_evt <= 1'h0;
		pulse_input_evt <= 1'h0;
		pulse_count <= 16'h3c5a;
		ext_drive <= 8'hff;
		repeat (6) @(posedge pclk);
		presetn <= 1'h1;
		check("oe_rst", 32'(pin_oe_n), 32'hff);
		rdc(IDX_FORCE, 32'h0);
		rdc(IDX_MASK, 32'h0);
		rdc(IDX_SCR1, 32'h0);
		rdc(IDX_OVERFLOW_TOGGLE_ENABLE, 32'h0);
		apb(1'h0, 6'h10, 32'h0, v1, e);
		check("unmapped_err", 32'(e), 32'h1);
		check("unmapped_data", v1, 32'h0);
		cyc(20);
		rdc(IDX_CNT_HI, 32'h0);
		wr(IDX_CNT_HI, 32'h1234);
		rdc(IDX_CNT_HI, 32'h0);
		test_mode <= 1'h1;
		wr(IDX_CNT_HI, 32'hfff0);
		test_mode <= 1'h0;
		rdc(IDX_CNT_HI, 32'hfff0);
		rdc(IDX_CNT_LO, 32'hf0);
		wr(IDX_SELECT, 32'hec);
		wr(IDX_SCR2, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wr(IDX_ACT1, 32'(act_code[i]) << 4);
			wr(IDX_FORCE, 32'h40);
			cyc(3);
			check("pin6", 32'(compare_output[6]), 32'(act_exp[i]));
		end
		check("flag6", 32'(channel_flags[6]), 32'h0);
		rdc(IDX_FORCE, 32'h0);
		wr(IDX_ACT1, 32'h0);
		cyc(3);
		check("oe6_off", 32'(pin_oe_n[6]), 32'h1);
		// Channel 2 asks to set, the channel 7 data must win
		wr(IDX_MASK, 32'h0c);
		wr(IDX_ODATA, 32'h08);
		wr(IDX_ACT2, 32'h30);
		wr(IDX_FORCE, 32'h84);
		cyc(3);
		check("pin3", 32'(compare_output[3]), 32'h1);
		check("oe3", 32'(pin_oe_n[3]), 32'h0);
		check("pin2", 32'(compare_output[2]), 32'h0);
		wr(IDX_ACT1, 32'h04);
		wr(6'h1a, 32'h8000);
		wr(IDX_OVERFLOW_TOGGLE_ENABLE, 32'h20);
		wr(IDX_SCR1, 32'h80);
		for (int n = 0; n < 100 && wrap_flag !== 1'h1; n++) begin
			@(posedge pclk);
		end
		check("wrap", 32'(wrap_flag), 32'h1);
		check("pin5", 32'(compare_output[5]), 32'h1);
		for (int i = 0; i < 6; i++) begin
			wr(IDX_SCR1, 32'(md_scr[i]));
			cpu_wait <= md_wt[i];
			cpu_freeze <= md_fz[i];
			apb(1'h0, IDX_CNT_HI, 32'h0, v1, e);
			apb(1'h0, IDX_CNT_HI, 32'h0, v2, e);
			check("cnt_step", 32'(v2[15:0] - v1[15:0]), 32'(md_d[i]));
		end
		cpu_wait <= 1'h0;
		cpu_freeze <= 1'h0;
		cnt64(2);
		wr(IDX_SCR2, 32'h2);
		apb(1'h0, IDX_CNT_HI, 32'h0, v1, e);
		cyc(5);
		apb(1'h0, IDX_CNT_HI, 32'h0, v2, e);
		check("cnt_div4", 32'(v2[15:0] - v1[15:0]), 32'h2);
		wr(IDX_SCR2, 32'h0);
		wr(IDX_SCR1, 32'h0);
		// A pulse launched before the write may still be on the pin
		cyc(1);
		cnt64(0);
		wr(IDX_SCR1, 32'h80);
		check("wrap_kept", 32'(wrap_flag), 32'h1);
		wr(6'h16, 32'h0);
		cyc(2);
		check("flag3_kept", 32'(channel_flags[3]), 32'h1);
		wr(IDX_SCR1, 32'h90);
		apb(1'h0, IDX_CNT_LO, 32'h0, v1, e);
		check("cnt_lo_err", 32'(e), 32'h0);
		cyc(2);
		check("wrap_fast", 32'(wrap_flag), 32'h0);
		wr(IDX_CMP_FIRST, 32'h0);
		cyc(2);
		check("flag2_fast", 32'(channel_flags[2]), 32'h0);
		check("flag3_left", 32'(channel_flags[3]), 32'h1);
		ext_drive[4] <= 1'h0;
		cyc(3);
		ext_drive[4] <= 1'h1;
		cyc(4);
		check("flag4_cap", 32'(channel_flags[4]), 32'h1);
		apb(1'h0, 6'h18, 32'h0, v1, e);
		cyc(2);
		check("flag4_fast", 32'(channel_flags[4]), 32'h0);
		pulse_wrap_evt <= 1'h1;
		pulse_input_evt <= 1'h1;
		cyc(1);
		pulse_wrap_evt <= 1'h0;
		pulse_input_evt <= 1'h0;
		cyc(2);
		rdc(IDX_PFLG, 32'h3);
		rdc(IDX_PCNT_LO, 32'h5a);
		cyc(2);
		rdc(IDX_PFLG, 32'h0);
		final_report();
	end
endmodule : tb
`default_nettype wire

/* verif/tcc_pin_model.sv */
`default_nettype none
module tcc_pin_model (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Device side
	input  wire logic [7:0] compare_output,
	input  wire logic [7:0] pin_oe_n,
	// Outside world
	input  wire logic [7:0] ext_drive,
	output var  logic [7:0] pin_level,
	output var  logic [7:0] capture_evt
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] last_r;
	// Released pins follow the outside source, never the old timer level
	always_comb begin
		pin_level = (~pin_oe_n & compare_output) | (pin_oe_n & ext_drive);
	end
	// Only pins the timer does not drive can produce a capture edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_r      <= 8'hff;
			capture_evt <= 8'h00;
		end else begin
			last_r      <= pin_level;
			capture_evt <= pin_level & ~last_r & pin_oe_n & 8'hfc;
		end
	end
endmodule : tcc_pin_model
`default_nettype wire
